// File: verilog/supply_clock_monitor_pkg.sv
// Shared constants and carrier types for the supply and clock monitor configuration registers
package supply_clock_monitor_pkg;

   // Register offsets on the internal register access port
   localparam logic [7:0] SUPPLY_ENABLES_OFFSET = 8'h41;
   localparam logic [7:0] SUPPLY_THRESHOLDS_OFFSET = 8'h42;
   localparam logic [7:0] CLOCK_ENABLES_OFFSET = 8'h43;

   // Reset values
   localparam logic [15:0] SUPPLY_ENABLES_RESET = 16'h0000;
   localparam logic [15:0] SUPPLY_THRESHOLDS_RESET = 16'h10f0;
   localparam logic [15:0] CLOCK_ENABLES_RESET = 16'h0000;

   // Writable bits of each register; all other bits are read-only zero
   localparam logic [15:0] SUPPLY_ENABLES_WR_MASK = 16'hffff;
   localparam logic [15:0] SUPPLY_THRESHOLDS_WR_MASK = 16'h30f0;
   localparam logic [15:0] CLOCK_ENABLES_WR_MASK = 16'hfc07;

   // Writable reserved field of the clock register, which software keeps at zero
   localparam logic [15:0] CLOCK_RSVD_FIELD_MASK = 16'hfc00;

   // Overtemperature warning threshold codes (code zero has no defined threshold)
   localparam logic [1:0] OVERTEMP_100C = 2'h1;
   localparam logic [1:0] OVERTEMP_120C = 2'h2;
   localparam logic [1:0] OVERTEMP_140C = 2'h3;

   // Register access request from the serial interface logic
   typedef struct packed {
      logic wr_en;
      logic rd_en;
      logic [7:0] addr;
      logic [15:0] wdata;
   } reg_req_type;

   // Supply monitor enables, bit 15 first
   typedef struct packed {
      logic analog_reg_overvoltage_mon_enable;
      logic analog_reg_undervoltage_mon_enable;
      logic interface_reg_overvoltage_mon_enable;
      logic interface_reg_undervoltage_mon_enable;
      logic core_reg_overvoltage_mon_enable;
      logic core_reg_undervoltage_mon_enable;
      logic analog_reg_oscillation_mon_enable;
      logic interface_reg_oscillation_mon_enable;
      logic core_reg_oscillation_mon_enable;
      logic analog_reg_overtemp_warn_enable;
      logic interface_reg_overtemp_warn_enable;
      logic analog_reg_current_limit_enable;
      logic interface_reg_current_limit_enable;
      logic analog_ground_a_disconnect_enable;
      logic analog_ground_b_disconnect_enable;
      logic digital_ground_disconnect_enable;
   } supply_enables_type;

   // Supply monitor threshold selections, bit 15 first
   typedef struct packed {
      logic [1:0] reserved_hi;
      logic interface_overvoltage_threshold_sel;
      logic interface_undervoltage_threshold_sel;
      logic [3:0] reserved_mid;
      logic [1:0] analog_overtemp_threshold_sel;
      logic [1:0] interface_overtemp_threshold_sel;
      logic [3:0] reserved_lo;
   } supply_thresholds_type;

   // Clock monitor enables, bit 15 first
   typedef struct packed {
      logic [5:0] reserved_wr;
      logic [6:0] reserved_ro;
      logic main_clock_freq_monitor_enable;
      logic diag_oscillator_watchdog_enable;
      logic main_clock_watchdog_enable;
   } clock_enables_type;

endpackage

// File: verilog/supply_clock_monitor_cfg_regs.sv
// Configuration register bank for the supply and clock supervision logic
`timescale 1ns/10ps

// Overview of operation
// - Bits 15,14 enable analog regulator OV/UV
// - Bits 13,12 enable interface regulator OV/UV
// - Bits 11,10 enable core regulator OV/UV
// - Bits 9..7 enable regulator oscillation monitors
// - Bits 6,5 enable overtemperature warning monitors
// - Bits 4,3 enable regulator current limits
// - Bits 2..0 enable ground disconnect monitors
// - Enables at 41h, read/write, reset zero
// - Bit 13 picks interface overvoltage threshold
// - Bit 12 picks interface undervoltage threshold
// - Field 7:6 picks analog overtemperature threshold
// - Field 5:4 picks interface overtemperature threshold
// - Threshold reserved bits read zero
// - Thresholds at 42h, reset 10F0h
// - Clock bits 9:3 read zero; 43h, reset zero
// - Clock bit 2 enables frequency monitor
// - Clock bit 1 enables oscillator watchdog
// - Clock bit 0 enables main clock watchdog
module supply_clock_monitor_cfg_regs
   import supply_clock_monitor_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Register access from the serial interface logic
   input wire reg_req_type reg_req,
   output logic [15:0] reg_rd_data,
   output logic reg_rd_valid,
   output logic reg_rsvd_write_seen,
   // Configuration to the monitor circuits
   output supply_enables_type supply_enables,
   output supply_thresholds_type supply_thresholds,
   output clock_enables_type clock_enables
);

   // Merge new data into the writable bits only
   function automatic logic [15:0] write_merge(input logic [15:0] old_value, input logic [15:0] new_value,
                                               input logic [15:0] wr_mask);
      write_merge = (old_value & ~wr_mask) | (new_value & wr_mask);
   endfunction

   // Address decode against one register offset
   function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offset);
      reg_hit = (addr == offset);
   endfunction

   supply_enables_type supply_enables_r;
   supply_thresholds_type supply_thresholds_r;
   clock_enables_type clock_enables_r;
   logic [15:0] rd_data_r;
   logic [15:0] rd_data_nxt;
   logic rd_valid_r;
   logic rsvd_write_r;
   logic wr_enables;
   logic wr_thresholds;
   logic wr_clock;

   // Write strobes per register; the access port is on this clock, so no synchroniser
   assign wr_enables = reg_req.wr_en && reg_hit(reg_req.addr, SUPPLY_ENABLES_OFFSET);
   assign wr_thresholds = reg_req.wr_en && reg_hit(reg_req.addr, SUPPLY_THRESHOLDS_OFFSET);
   assign wr_clock = reg_req.wr_en && reg_hit(reg_req.addr, CLOCK_ENABLES_OFFSET);

   // Supply monitor enables, every bit writable
   // analog interface core
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         supply_enables_r <= supply_enables_type'(SUPPLY_ENABLES_RESET);
      end
      else if (wr_enables)
      begin
         supply_enables_r <= supply_enables_type'(write_merge(supply_enables_r, reg_req.wdata,
                                                              SUPPLY_ENABLES_WR_MASK));
      end
   end

   // Threshold selections; the mask keeps reserved bits at zero whatever is written
   // voltage and overtemperature threshold selects
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         supply_thresholds_r <= supply_thresholds_type'(SUPPLY_THRESHOLDS_RESET);
      end
      else if (wr_thresholds)
      begin
         supply_thresholds_r <= supply_thresholds_type'(write_merge(supply_thresholds_r, reg_req.wdata,
                                                                    SUPPLY_THRESHOLDS_WR_MASK));
      end
   end

   // Clock monitor enables; the upper reserved field is stored because it is writable
   // clock enable bits
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         clock_enables_r <= clock_enables_type'(CLOCK_ENABLES_RESET);
      end
      else if (wr_clock)
      begin
         clock_enables_r <= clock_enables_type'(write_merge(clock_enables_r, reg_req.wdata,
                                                            CLOCK_ENABLES_WR_MASK));
      end
   end

   // Flag a nonzero write into the clock reserved field, for debug visibility only
   // software keeps zeros
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rsvd_write_r <= 1'b0;
      end
      else
      begin
         rsvd_write_r <= wr_clock && ((reg_req.wdata & CLOCK_RSVD_FIELD_MASK) != 16'h0000);
      end
   end

   // Read multiplexer; unmapped offsets return zero
   // readback of stored values
   always_comb
   begin
      rd_data_nxt = 16'h0000;
      case (reg_req.addr)
         SUPPLY_ENABLES_OFFSET: rd_data_nxt = supply_enables_r;
         SUPPLY_THRESHOLDS_OFFSET: rd_data_nxt = supply_thresholds_r;
         CLOCK_ENABLES_OFFSET: rd_data_nxt = clock_enables_r;
         default: rd_data_nxt = 16'h0000;
      endcase
   end

   // Read data is captured one cycle after the request; a same-cycle write is not yet visible
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_data_r <= 16'h0000;
         rd_valid_r <= 1'b0;
      end
      else
      begin
         rd_valid_r <= reg_req.rd_en;
         if (reg_req.rd_en)
         begin
            rd_data_r <= rd_data_nxt;
         end
      end
   end

   // Outputs straight from the flip-flops
   assign reg_rd_data = rd_data_r;
   assign reg_rd_valid = rd_valid_r;
   assign reg_rsvd_write_seen = rsvd_write_r;
   assign supply_enables = supply_enables_r;
   assign supply_thresholds = supply_thresholds_r;
   assign clock_enables = clock_enables_r;

   // Checks on the register behaviour
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   // Enables take the written word on the next edge
   a_enables_write:
      assert property (wr_enables |=> supply_enables == $past(reg_req.wdata))
      else $error("supply enables did not take written value");

   // Enables hold when not written
   a_enables_hold:
      assert property (!wr_enables |=> $stable(supply_enables))
      else $error("supply enables changed without a write");

   // Reset values seen on the first cycle after release
   a_reset_values:
      assert property (!$past(rst_n) |-> (supply_enables == SUPPLY_ENABLES_RESET)
                       && (supply_thresholds == SUPPLY_THRESHOLDS_RESET)
                       && (clock_enables == CLOCK_ENABLES_RESET))
      else $error("register not at reset value after reset");

   // Threshold selects follow the written bits
   a_thresh_write:
      assert property (wr_thresholds |=> (supply_thresholds.interface_overvoltage_threshold_sel
                       == $past(reg_req.wdata[13])) && (supply_thresholds.analog_overtemp_threshold_sel
                       == $past(reg_req.wdata[7:6])) && (supply_thresholds.interface_overtemp_threshold_sel
                       == $past(reg_req.wdata[5:4])) && (supply_thresholds.interface_undervoltage_threshold_sel
                       == $past(reg_req.wdata[12])))
      else $error("threshold selects did not take written value");

   // Threshold reserved bits stay zero
   a_thresh_reserved:
      assert property ((supply_thresholds & ~SUPPLY_THRESHOLDS_WR_MASK) == 16'h0000)
      else $error("threshold reserved bits not zero");

   // Clock read-only bits stay zero while enables follow the write
   a_clock_write:
      assert property (wr_clock |=> (clock_enables.reserved_ro == 7'h00)
                       && (clock_enables[2:0] == $past(reg_req.wdata[2:0])))
      else $error("clock enables wrong after write");

   // Threshold read returns valid and the stored value of the threshold register
   a_read_back:
      assert property (reg_req.rd_en && reg_hit(reg_req.addr, SUPPLY_THRESHOLDS_OFFSET)
                       |=> reg_rd_valid && (reg_rd_data == $past(supply_thresholds)))
      else $error("threshold read returned wrong data");

   // Unmapped reads return zero
   a_unmapped_read:
      assert property (reg_req.rd_en && (reg_req.addr != SUPPLY_ENABLES_OFFSET)
                       && (reg_req.addr != SUPPLY_THRESHOLDS_OFFSET) && (reg_req.addr != CLOCK_ENABLES_OFFSET)
                       |=> (reg_rd_data == 16'h0000))
      else $error("unmapped read not zero");

   // Clock write read back on the next cycle, checked two cycles after the write
   a_write_then_read:
      assert property (wr_clock ##1 (reg_req.rd_en && !reg_req.wr_en
                       && reg_hit(reg_req.addr, CLOCK_ENABLES_OFFSET))
                       |=> reg_rd_data == ($past(reg_req.wdata, 2) & CLOCK_ENABLES_WR_MASK))
      else $error("clock register did not read back written value");

   // Threshold selections hold when not written
   a_thresh_hold:
      assert property (!wr_thresholds |=> $stable(supply_thresholds))
      else $error("threshold selects changed without a write");

   // Clock enables hold when not written
   a_clock_hold:
      assert property (!wr_clock |=> $stable(clock_enables))
      else $error("clock enables changed without a write");

   // Field checks by name: a whole-word compare cannot see two struct members
   // declared in swapped order, so each named enable is held against its bit
   a_analog_fields:
      assert property (wr_enables |=>
                       (supply_enables.analog_reg_overvoltage_mon_enable == $past(reg_req.wdata[15]))
                       && (supply_enables.analog_reg_undervoltage_mon_enable == $past(reg_req.wdata[14])))
      else $error("analog regulator enables on wrong bits");

   // Interface regulator voltage monitor enables
   a_interface_fields:
      assert property (wr_enables |=>
                       (supply_enables.interface_reg_overvoltage_mon_enable == $past(reg_req.wdata[13]))
                       && (supply_enables.interface_reg_undervoltage_mon_enable == $past(reg_req.wdata[12])))
      else $error("interface regulator enables on wrong bits");

   // Core regulator voltage monitor enables
   a_core_fields:
      assert property (wr_enables |=>
                       (supply_enables.core_reg_overvoltage_mon_enable == $past(reg_req.wdata[11]))
                       && (supply_enables.core_reg_undervoltage_mon_enable == $past(reg_req.wdata[10])))
      else $error("core regulator enables on wrong bits");

   // Oscillation monitor enables
   a_oscillation_fields:
      assert property (wr_enables |=>
                       (supply_enables.analog_reg_oscillation_mon_enable == $past(reg_req.wdata[9]))
                       && (supply_enables.interface_reg_oscillation_mon_enable == $past(reg_req.wdata[8]))
                       && (supply_enables.core_reg_oscillation_mon_enable == $past(reg_req.wdata[7])))
      else $error("oscillation monitor enables on wrong bits");

   // Overtemperature warning monitor enables
   a_overtemp_fields:
      assert property (wr_enables |=>
                       (supply_enables.analog_reg_overtemp_warn_enable == $past(reg_req.wdata[6]))
                       && (supply_enables.interface_reg_overtemp_warn_enable == $past(reg_req.wdata[5])))
      else $error("overtemperature warning enables on wrong bits");

   // Current limit enables
   a_current_limit:
      assert property (wr_enables |=>
                       (supply_enables.analog_reg_current_limit_enable == $past(reg_req.wdata[4]))
                       && (supply_enables.interface_reg_current_limit_enable == $past(reg_req.wdata[3])))
      else $error("current limit enables on wrong bits");

   // Ground disconnect monitor enables
   a_ground_fields:
      assert property (wr_enables |=>
                       (supply_enables.analog_ground_a_disconnect_enable == $past(reg_req.wdata[2]))
                       && (supply_enables.analog_ground_b_disconnect_enable == $past(reg_req.wdata[1]))
                       && (supply_enables.digital_ground_disconnect_enable == $past(reg_req.wdata[0])))
      else $error("ground disconnect enables on wrong bits");

   // Clock monitor and watchdog enables
   a_clock_fields:
      assert property (wr_clock |=>
                       (clock_enables.main_clock_freq_monitor_enable == $past(reg_req.wdata[2]))
                       && (clock_enables.diag_oscillator_watchdog_enable == $past(reg_req.wdata[1]))
                       && (clock_enables.main_clock_watchdog_enable == $past(reg_req.wdata[0])))
      else $error("clock enables on wrong bits");

   // Every read request is answered on the next cycle
   a_valid_after_read:
      assert property (reg_req.rd_en |=> reg_rd_valid)
      else $error("read not answered with valid");

   // Valid never shows without a read
   a_valid_one_cycle:
      assert property (!reg_req.rd_en |=> !reg_rd_valid)
      else $error("read valid without a read request");

   // Read data stands until the next read
   a_rd_data_hold:
      assert property (!reg_req.rd_en |=> $stable(reg_rd_data))
      else $error("read data changed without a read");

   // Enables read back as stored
   a_enables_read_back:
      assert property (reg_req.rd_en && reg_hit(reg_req.addr, SUPPLY_ENABLES_OFFSET)
                       |=> reg_rd_data == $past(supply_enables))
      else $error("enables read returned wrong data");

   // Clock register reads back as stored
   a_clock_read_back:
      assert property (reg_req.rd_en && reg_hit(reg_req.addr, CLOCK_ENABLES_OFFSET)
                       |=> reg_rd_data == $past(clock_enables))
      else $error("clock read returned wrong data");

   // Threshold reserved bits read zero on the bus
   a_thresh_read_zero:
      assert property (reg_req.rd_en && reg_hit(reg_req.addr, SUPPLY_THRESHOLDS_OFFSET)
                       |=> (reg_rd_data & ~SUPPLY_THRESHOLDS_WR_MASK) == 16'h0000)
      else $error("threshold reserved bits read nonzero");

   // Debug flag stays low unless the clock register is written
   a_rsvd_flag:
      assert property (!wr_clock |=> !reg_rsvd_write_seen)
      else $error("reserved write flag without a clock write");

   // Writes to unmapped offsets change nothing
   a_unmapped_write:
      assert property (reg_req.wr_en && !wr_enables && !wr_thresholds && !wr_clock
                       |=> $stable(supply_enables) && $stable(supply_thresholds) && $stable(clock_enables))
      else $error("unmapped write changed a register");

   // Read port is idle on the first cycle after reset
   a_read_reset:
      assert property (!$past(rst_n) |-> (reg_rd_data == 16'h0000) && !reg_rd_valid)
      else $error("read port not idle after reset");

   // Main scenarios
   c_enables_all: cover property (wr_enables && reg_req.wdata == 16'hffff);
   c_thresh_low: cover property (wr_thresholds ##1 supply_thresholds.analog_overtemp_threshold_sel == OVERTEMP_100C);
   c_clock_readback: cover property (wr_clock ##1 reg_req.rd_en && reg_hit(reg_req.addr, CLOCK_ENABLES_OFFSET));
   c_clock_all: cover property (wr_clock && reg_req.wdata[2:0] == 3'h7);
   c_same_cycle: cover property (wr_enables && reg_req.rd_en);

endmodule

// File: verification/testbench.sv
// Self-checking testbench for the monitor configuration register bank
`timescale 1ns/10ps
module testbench
   import supply_clock_monitor_pkg::*;
;
   logic sys_clk;
   logic rst_n;
   reg_req_type reg_req;
   logic [15:0] reg_rd_data;
   logic reg_rd_valid;
   logic reg_rsvd_write_seen;
   supply_enables_type supply_enables;
   supply_thresholds_type supply_thresholds;
   clock_enables_type clock_enables;
   int err_count;
   int cmp_count;
   int cycle_count;
   logic [15:0] shadow [3];
   logic [15:0] rd_seen;
   logic [15:0] val;
   logic [7:0] adr;

   supply_clock_monitor_cfg_regs dut (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .reg_req(reg_req),
      .reg_rd_data(reg_rd_data),
      .reg_rd_valid(reg_rd_valid),
      .reg_rsvd_write_seen(reg_rsvd_write_seen),
      .supply_enables(supply_enables),
      .supply_thresholds(supply_thresholds),
      .clock_enables(clock_enables)
   );

   // Free-running 250 MHz clock
   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   // Writable bits per offset; every other bit reads back zero
   function automatic logic [15:0] wmask(input logic [7:0] a);
      case (a)
         8'h41: return 16'hffff;
         8'h42: return 16'h30f0;
         8'h43: return 16'hfc07;
         default: return 16'h0000;
      endcase
   endfunction

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic end_of_test();
      $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // One request cycle; inputs change 1 ns after the edge, answer sampled 1 ns after the next
   task automatic access(input logic wr, input logic rd, input logic [7:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      #1;
      reg_req = '{wr_en: wr, rd_en: rd, addr: a, wdata: d};
      @(posedge sys_clk);
      #1;
      reg_req.wr_en = 1'b0;
      reg_req.rd_en = 1'b0;
      rd_seen = reg_rd_data;
      // Valid stands one cycle after a read request only
      check("rd_valid", {15'h0, reg_rd_valid}, {15'h0, rd});
      if (wmask(a) != 16'h0000)
         shadow[a - 8'h41] = wr ? (d & wmask(a)) : shadow[a - 8'h41];
   endtask

   // Write, then a read of the same offset on the very next cycle with no idle gap
   task automatic write_then_read(input logic [7:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      #1;
      reg_req = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
      @(posedge sys_clk);
      #1;
      reg_req.wr_en = 1'b0;
      reg_req.rd_en = 1'b1;
      if (wmask(a) != 16'h0000)
         shadow[a - 8'h41] = d & wmask(a);
      @(posedge sys_clk);
      #1;
      reg_req.rd_en = 1'b0;
      rd_seen = reg_rd_data;
      check("rd_valid", {15'h0, reg_rd_valid}, 16'h0001);
   endtask

   task automatic read_check(input logic [7:0] a);
      val = (wmask(a) != 16'h0000) ? shadow[a - 8'h41] : 16'h0000;
      access(1'b0, 1'b1, a, 16'h0000);
      check($sformatf("read %h", a), rd_seen, val);
   endtask

   task automatic check_outs();
      check("supply_enables", supply_enables, shadow[0]);
      check("supply_thresholds", supply_thresholds, shadow[1]);
      check("clock_enables", clock_enables, shadow[2]);
   endtask

   task automatic reset_pulse(input int n);
      rst_n = 1'b0;
      repeat (n) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
      shadow = '{16'h0000, 16'h10f0, 16'h0000};
   endtask

   // Hang guard: well above the few hundred cycles the tests need
   always @(posedge sys_clk)
   begin
      cycle_count++;
      if (cycle_count == 5000)
      begin
         err_count++;
         end_of_test();
      end
   end

   initial
   begin
      reg_req = '0;
      err_count = 0;
      cmp_count = 0;
      cycle_count = 0;
      void'($urandom(87));
      reset_pulse(20);
      // Reset values at all three offsets
      for (int i = 0; i < 3; i++)
         read_check(8'h41 + 8'(i));
      check_outs();
      check("thr_sel", {12'h0, supply_thresholds[13:12], supply_thresholds[7:6]}, 16'h0007);
      $display("test reset_values done");
      // Walking one over the enable register, then single fields by name
      for (int i = 0; i < 16; i++)
      begin
         access(1'b1, 1'b0, 8'h41, 16'h0001 << i);
         check("walk", supply_enables, 16'h0001 << i);
      end
      check("analog_ov", {15'h0, supply_enables.analog_reg_overvoltage_mon_enable}, 16'h0001);
      access(1'b1, 1'b0, 8'h41, 16'h0001);
      check("ground_d", {15'h0, supply_enables.digital_ground_disconnect_enable}, 16'h0001);
      access(1'b1, 1'b0, 8'h41, 16'hffff);
      check("all_on", supply_enables, 16'hffff);
      $display("test enable_walk done");
      // Every overtemperature code in both fields, voltage selects toggled
      for (int c = 0; c < 4; c++)
      begin
         access(1'b1, 1'b0, 8'h42, {2'h3, 2'(c), 4'hf, 2'(c), 2'(3 - c), 4'hf});
         check("otw_sel", {12'h0, supply_thresholds[7:4]}, {12'h0, 2'(c), 2'(3 - c)});
         check("uv_ov_sel", {14'h0, supply_thresholds[13:12]}, {14'h0, 2'(c)});
         read_check(8'h42);
      end
      $display("test threshold_codes done");
      // Read-only bits set in the write data must read zero
      access(1'b1, 1'b0, 8'h43, 16'h03ff);
      check("clk_ro", clock_enables, 16'h0007);
      read_check(8'h43);
      $display("test read_only done");
      // Unmapped offsets: writes ignored, reads return zero
      for (int i = 0; i < 16; i++)
      begin
         adr = (i < 8) ? 8'h40 - 8'(i) : 8'h44 + 8'(i);
         access(1'b1, 1'b0, adr, 16'hffff);
         read_check(adr);
         check_outs();
      end
      $display("test unmapped done");
      // Read and write in one cycle: the read sees the old contents
      val = shadow[0];
      access(1'b1, 1'b1, 8'h41, ~val);
      check("rd_old", rd_seen, val);
      read_check(8'h41);
      $display("test same_cycle done");
      // Write then read on the next cycle at each offset
      for (int n = 0; n < 3; n++)
      begin
         adr = 8'h41 + 8'(n);
         val = (adr == 8'h43) ? (16'($urandom) & 16'h03ff) : 16'($urandom);
         write_then_read(adr, val);
         check("wr_rd", rd_seen, val & wmask(adr));
      end
      $display("test back_to_back done");
      // Random traffic; clock register writes keep bits 15:10 zero
      for (int n = 0; n < 60; n++)
      begin
         adr = 8'h41 + 8'($urandom % 3);
         val = 16'($urandom);
         if (adr == 8'h43)
            val = val & 16'h03ff;
         access(1'b1, 1'b0, adr, val);
         check("rsvd_flag", {15'h0, reg_rsvd_write_seen}, 16'h0000);
         read_check(8'h41 + 8'($urandom % 3));
         check_outs();
      end
      $display("test random_traffic done");
      // Reset in mid-run restores defaults
      @(posedge sys_clk);
      #1;
      reset_pulse(3);
      check_outs();
      read_check(8'h42);
      $display("test mid_reset done");
      end_of_test();
   end
endmodule
